// >>> logic/abrd_defs.svh
// Offsets, field positions, reset values, code band limits and sample timing
// Assumes a 125 MHz system clock and a 32-bit register port with byte addresses
`ifndef ABRD_DEFS_SVH
`define ABRD_DEFS_SVH

// Register byte offsets
`define ABRD_OFF_CTRL      8'h00
`define ABRD_OFF_OUT_DATA  8'h04
`define ABRD_OFF_SUBST     8'h08
`define ABRD_OFF_STATUS    8'h0c
`define ABRD_OFF_IN_DATA   8'h10
`define ABRD_OFF_IRQ_STAT  8'h14
`define ABRD_OFF_IRQ_MASK  8'h18

// Control register fields
`define ABRD_CTRL_RUN      0
`define ABRD_CTRL_CURRENT  1
`define ABRD_CTRL_SUBST    2
`define ABRD_CTRL_SMOOTH   4:3
`define ABRD_CTRL_INTEG    6:5
`define ABRD_CTRL_W        7

// Reset values
`define ABRD_CTRL_RST      7'h00
`define ABRD_SUBST_RST     16'h0000
`define ABRD_OUT_RST       16'h0000
`define ABRD_MASK_RST      5'h00

// Interrupt status bits
`define ABRD_IRQ_OUT_ERR   0
`define ABRD_IRQ_IN_ERR    1
`define ABRD_IRQ_SHORT     2
`define ABRD_IRQ_WIRE      3
`define ABRD_IRQ_UPDATE    4
`define ABRD_IRQ_W         5

// Signed code band limits
`define ABRD_RATED_POS     16'sh6c00
`define ABRD_OVF_MIN       16'sh7f00
`define ABRD_RATED_NEG     16'sh9400
`define ABRD_UNDER_MIN     16'sh8100

// Sample periods in ns and the clock rate in MHz
`define ABRD_CLK_MHZ       125
`define ABRD_T400_NS       156000
`define ABRD_T60_NS        1042000
`define ABRD_T50_NS        1250000
`define ABRD_T10_NS        6250000

`endif

// >>> logic/abrd_pkg.sv
// Types shared by the code range logic and its helpers
// Assumes nothing beyond a SystemVerilog compiler
package abrd_pkg;

  // Band that a signed data word falls in
  typedef enum logic [2:0] {
    BAND_RATED,
    BAND_OVERSHOOT,
    BAND_UNDERSHOOT,
    BAND_OVERFLOW,
    BAND_UNDERFLOW
  } codeBand_t;

  // Smoothing window selection
  typedef enum logic [1:0] {
    SMOOTH_NONE,
    SMOOTH_WEAK,
    SMOOTH_MEDIUM,
    SMOOTH_STRONG
  } smooth_t;

endpackage : abrd_pkg

// >>> logic/code_classifier.sv
// Combinational band classifier for one signed 16-bit data word
// Assumes the caller registers the result where timing matters
`timescale 1ns/100ps
`include "abrd_defs.svh"

module code_classifier (
  input  wire logic signed [15:0] code,
  input  wire logic               currentMode,
  output abrd_pkg::codeBand_t     band
);
  import abrd_pkg::*;

  localparam logic signed [15:0] RatedPos = `ABRD_RATED_POS;
  localparam logic signed [15:0] OvfMin   = `ABRD_OVF_MIN;
  localparam logic signed [15:0] RatedNeg = `ABRD_RATED_NEG;
  localparam logic signed [15:0] UnderMin = `ABRD_UNDER_MIN;

  // Highest band first; current span has nothing below zero
  always_comb begin
    if (code >= OvfMin) begin
      band = BAND_OVERFLOW;
    end else if (code > RatedPos) begin
      band = BAND_OVERSHOOT;
    end else if (currentMode && (code < 16'sh0000)) begin
      band = BAND_UNDERFLOW;
    end else if (code < UnderMin) begin
      band = BAND_UNDERFLOW;
    end else if (code < RatedNeg) begin
      band = BAND_UNDERSHOOT;
    end else begin
      band = BAND_RATED;
    end
  end

endmodule : code_classifier

// >>> logic/sample_averager.sv
// Moving average over the last 1, 4, 16 or 32 input samples
// Assumes sampleTick is a one-cycle pulse on clk_sys and sampleIn is synchronous
`timescale 1ns/100ps

module sample_averager #(
  parameter int DEPTH = 32,
  parameter int W     = 16
) (
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                sampleTick,
  input  wire logic signed [W-1:0] sampleIn,
  input  abrd_pkg::smooth_t        smoothSel,
  output logic signed [W-1:0]      avgOut,
  output logic                     avgValid
);
  import abrd_pkg::*;

  localparam int SW = W + $clog2(DEPTH) + 1;

  logic signed [W-1:0]  hist_q [DEPTH];
  logic signed [W-1:0]  hist_d [DEPTH];
  logic signed [SW-1:0] term   [DEPTH];
  logic [5:0]           winLen;
  logic [2:0]           winShift;
  logic signed [SW-1:0] sum;
  logic signed [SW-1:0] scaled;
  logic                 pend_q, pend_d;
  logic signed [W-1:0]  avg_q, avg_d;

  // Window length and divide shift
  always_comb begin
    case (smoothSel)
      SMOOTH_WEAK:   begin winLen = 6'd4;  winShift = 3'd2; end
      SMOOTH_MEDIUM: begin winLen = 6'd16; winShift = 3'd4; end
      SMOOTH_STRONG: begin winLen = 6'd32; winShift = 3'd5; end
      default:       begin winLen = 6'd1;  winShift = 3'd0; end
    endcase
  end

  // History shift and window masking per entry
  for (genvar i = 0; i < DEPTH; i++) begin : gHist
    if (i == 0) begin : gHead
      assign hist_d[i] = sampleTick ? sampleIn : hist_q[i];
    end else begin : gBody
      assign hist_d[i] = sampleTick ? hist_q[i-1] : hist_q[i];
    end
    assign term[i] = (i < int'(winLen)) ? SW'(hist_q[i]) : '0;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        hist_q[i] <= '0;
      end else begin
        hist_q[i] <= hist_d[i];
      end
    end
  end

  // Window sum, scaled result one cycle after the shift
  always_comb begin
    sum = '0;
    for (int k = 0; k < DEPTH; k++) begin
      sum = sum + term[k];
    end
    scaled = sum >>> winShift;
    pend_d = sampleTick;
    avg_d  = pend_q ? scaled[W-1:0] : avg_q;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pend_q <= 1'b0;
      avg_q  <= '0;
    end else begin
      pend_q <= pend_d;
      avg_q  <= avg_d;
    end
  end

  assign avgOut   = avg_q;
  assign avgValid = pend_q;

endmodule : sample_averager

// >>> logic/analog_board_code_range_logic.sv
// Code range, reaction and diagnostic logic of the analog signal board
// Assumes a host on the register port at clk_sys; ADC code and fault pins are asynchronous
// Assumes the converter word may change at any edge; it is filtered after capture
// Assumes sample period parameters are whole cycle counts of at least one
// Assumes one clock; only the pins and the converter word cross into it
//
// Function
// - Voltage mode: signed code, +-27648 is full rated output, linear between.
// - Current mode: 0..27648 maps to zero..full current; negatives out of span.
// - Voltage output bands: overshoot, undershoot driven; overflow, underflow beyond.
// - Current output: 27649..32511 overshoot driven; 32512 up overflow, not driven.
// - Overflow or underflow output drives substitute or holds last, per stop reaction.
// - On run to stop keep last value or substitute; substitute resets to zero.
// - Short-to-ground diagnostic, evaluated only in voltage mode.
// - Wire-break diagnostic, evaluated only in current mode.
// - Bipolar input codes classified rated, overshoot, overflow, undershoot, underflow.
// - Input smoothing averages over 1, 4, 16 or 32 consecutive samples.
// - Input sampled every 0.156/1.042/1.250/6.250 ms; value updated once per period.
`timescale 1ns/100ps
`include "abrd_defs.svh"

module analog_board_code_range_logic #(
  parameter int unsigned SAMP_CYC_400 = (`ABRD_T400_NS * `ABRD_CLK_MHZ) / 1000,
  parameter int unsigned SAMP_CYC_60  = (`ABRD_T60_NS * `ABRD_CLK_MHZ) / 1000,
  parameter int unsigned SAMP_CYC_50  = (`ABRD_T50_NS * `ABRD_CLK_MHZ) / 1000,
  parameter int unsigned SAMP_CYC_10  = (`ABRD_T10_NS * `ABRD_CLK_MHZ) / 1000
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdata,
  output logic             irq,
  output logic      [15:0] dacCode,
  output logic             dacCurrentMode,
  input  wire logic [15:0] adcCode,
  input  wire logic        shortToGndPin,
  input  wire logic        wireBreakPin
);
  import abrd_pkg::*;

  // Sample period reload values, one less than the period
  // Counter runs 0 to reload, one tick per full period
  localparam logic [19:0] Reload400 = 20'(SAMP_CYC_400 - 1);
  localparam logic [19:0] Reload60  = 20'(SAMP_CYC_60 - 1);
  localparam logic [19:0] Reload50  = 20'(SAMP_CYC_50 - 1);
  localparam logic [19:0] Reload10  = 20'(SAMP_CYC_10 - 1);

  // Host registers, synchronisers and derived flags
  logic [`ABRD_CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [15:0]             outData_q, outData_d;
  logic [15:0]             subst_q, subst_d;
  logic [`ABRD_IRQ_W-1:0]  irqStat_q, irqStat_d;
  logic [`ABRD_IRQ_W-1:0]  irqMask_q, irqMask_d;
  logic [31:0]             rdata_q, rdata_d;
  logic [15:0]             dac_q, dac_d;
  logic [15:0]             adcMeta_q, adcSync_q;
  logic [15:0]             adcPrev_q, adcHold_q, adcHold_d;
  logic [1:0]              pinMeta_q, pinSync_q;
  logic                    outErr_q, inErr_q, short_q, wire_q;
  logic                    outErr, inErr, shortFault, wireFault;
  logic [19:0]             sampCnt_q, sampCnt_d;
  logic [19:0]             reload;
  logic                    sampleTick;
  logic [`ABRD_IRQ_W-1:0]  irqEvent;
  logic                    running, currentMode, useSubst;
  codeBand_t               outBand, inBand;
  smooth_t                 smoothSel;
  logic signed [15:0]      avgCode;
  logic                    avgValid;

  // Control fields
  // Run and reaction bits are plain levels, no edge logic
  assign running     = ctrl_q[`ABRD_CTRL_RUN];
  assign currentMode = ctrl_q[`ABRD_CTRL_CURRENT];
  assign useSubst    = ctrl_q[`ABRD_CTRL_SUBST];
  assign smoothSel   = smooth_t'(ctrl_q[`ABRD_CTRL_SMOOTH]);

  // Two-stage capture of the asynchronous ADC word and fault pins
  // Each bit settles alone; the word is checked for agreement below
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adcMeta_q <= 16'h0000;
      adcSync_q <= 16'h0000;
      pinMeta_q <= 2'h0;
      pinSync_q <= 2'h0;
    end else begin
      adcMeta_q <= adcCode;
      adcSync_q <= adcMeta_q;
      pinMeta_q <= {wireBreakPin, shortToGndPin};
      pinSync_q <= pinMeta_q;
    end
  end

  // Word capture: take the synchronised word only once it held for two
  // edges, so bits caught mid-change never form a false sample
  assign adcHold_d = (adcSync_q == adcPrev_q) ? adcSync_q : adcHold_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      adcPrev_q <= 16'h0000;
      adcHold_q <= 16'h0000;
    end else begin
      adcPrev_q <= adcSync_q;
      adcHold_q <= adcHold_d;
    end
  end

  // Output band of the host word
  // Current mode folds negative codes into underflow
  code_classifier uOutClass (
    .code        (outData_q),
    .currentMode (currentMode),
    .band        (outBand)
  );

  // Input band, always judged on the bipolar span
  // Judged on the averaged word, as the host reads it
  code_classifier uInClass (
    .code        (avgCode),
    .currentMode (1'b0),
    .band        (inBand)
  );

  // Range flags and mode-gated diagnostics
  // Levels drop as soon as the code returns to range
  assign outErr     = (outBand == BAND_OVERFLOW) || (outBand == BAND_UNDERFLOW);
  assign inErr      = (inBand == BAND_OVERFLOW) || (inBand == BAND_UNDERFLOW);
  assign shortFault = pinSync_q[0] && !currentMode;
  assign wireFault  = pinSync_q[1] && currentMode;

  // Sample period counter for the selected integration time
  // A shorter period picked when the count is already past its reload ticks at once, no wrap wait
  always_comb begin
    case (ctrl_q[`ABRD_CTRL_INTEG])
      2'd1:    reload = Reload60;
      2'd2:    reload = Reload50;
      2'd3:    reload = Reload10;
      default: reload = Reload400;
    endcase
    sampleTick = (sampCnt_q >= reload);
    sampCnt_d  = sampleTick ? 20'h00000 : sampCnt_q + 20'h00001;
  end

  // Period counter register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sampCnt_q <= 20'h00000;
    end else begin
      sampCnt_q <= sampCnt_d;
    end
  end

  // Input smoothing window
  // Average lands two edges after the tick: shift, then scale
  sample_averager #(
    .DEPTH (32),
    .W     (16)
  ) uAvg (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .sampleTick (sampleTick),
    .sampleIn   (adcHold_q),
    .smoothSel  (smoothSel),
    .avgOut     (avgCode),
    .avgValid   (avgValid)
  );

  // Output drive: stop or out-of-band code takes substitute or holds
  // Stop outranks the band check; one reaction bit serves both
  always_comb begin
    if (!running) begin
      dac_d = useSubst ? subst_q : dac_q;
    end else if (outErr) begin
      dac_d = useSubst ? subst_q : dac_q;
    end else begin
      dac_d = outData_q;
    end
  end

  // Drive register, zero until the host runs it or selects a written substitute
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dac_q <= `ABRD_OUT_RST;
    end else begin
      dac_q <= dac_d;
    end
  end

  // Delayed copies for rising-edge events
  // Reset to idle levels, so no false event follows reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      outErr_q <= 1'b0;
      inErr_q  <= 1'b0;
      short_q  <= 1'b0;
      wire_q   <= 1'b0;
    end else begin
      outErr_q <= outErr;
      inErr_q  <= inErr;
      short_q  <= shortFault;
      wire_q   <= wireFault;
    end
  end

  // Event vector
  // Update bit pulses once per averaged sample
  always_comb begin
    irqEvent                     = '0;
    irqEvent[`ABRD_IRQ_OUT_ERR]  = outErr && !outErr_q;
    irqEvent[`ABRD_IRQ_IN_ERR]   = inErr && !inErr_q;
    irqEvent[`ABRD_IRQ_SHORT]    = shortFault && !short_q;
    irqEvent[`ABRD_IRQ_WIRE]     = wireFault && !wire_q;
    irqEvent[`ABRD_IRQ_UPDATE]   = avgValid;
  end

  // Register writes; sticky status cleared by one, a new event wins
  // Status and input words are read-only; writes there fall through
  always_comb begin
    ctrl_d    = ctrl_q;
    outData_d = outData_q;
    subst_d   = subst_q;
    irqMask_d = irqMask_q;
    irqStat_d = irqStat_q;
    if (regWrite) begin
      if (regAddr == `ABRD_OFF_CTRL) begin
        ctrl_d = regWdata[`ABRD_CTRL_W-1:0];
      end else if (regAddr == `ABRD_OFF_OUT_DATA) begin
        outData_d = regWdata[15:0];
      end else if (regAddr == `ABRD_OFF_SUBST) begin
        subst_d = regWdata[15:0];
      end else if (regAddr == `ABRD_OFF_IRQ_STAT) begin
        irqStat_d = irqStat_q & ~regWdata[`ABRD_IRQ_W-1:0];
      end else if (regAddr == `ABRD_OFF_IRQ_MASK) begin
        irqMask_d = regWdata[`ABRD_IRQ_W-1:0];
      end
    end
    irqStat_d = irqStat_d | irqEvent;
  end

  // Host registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_q    <= `ABRD_CTRL_RST;
      outData_q <= `ABRD_OUT_RST;
      subst_q   <= `ABRD_SUBST_RST;
      irqMask_q <= `ABRD_MASK_RST;
      irqStat_q <= '0;
    end else begin
      ctrl_q    <= ctrl_d;
      outData_q <= outData_d;
      subst_q   <= subst_d;
      irqMask_q <= irqMask_d;
      irqStat_q <= irqStat_d;
    end
  end

  // Read decode, data in the cycle after the strobe, unmapped reads zero
  // Registered, so data stand one cycle and drop back to zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (regRead) begin
      if (regAddr == `ABRD_OFF_CTRL) begin
        rdata_d = {25'h0000000, ctrl_q};
      end else if (regAddr == `ABRD_OFF_OUT_DATA) begin
        rdata_d = {16'h0000, outData_q};
      end else if (regAddr == `ABRD_OFF_SUBST) begin
        rdata_d = {16'h0000, subst_q};
      end else if (regAddr == `ABRD_OFF_STATUS) begin
        rdata_d = {21'h000000, running, wireFault, shortFault, inErr, outErr,
                   inBand, outBand};
      end else if (regAddr == `ABRD_OFF_IN_DATA) begin
        rdata_d = {16'h0000, avgCode};
      end else if (regAddr == `ABRD_OFF_IRQ_STAT) begin
        rdata_d = {27'h0000000, irqStat_q};
      end else if (regAddr == `ABRD_OFF_IRQ_MASK) begin
        rdata_d = {27'h0000000, irqMask_q};
      end
    end
  end

  // Read data register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Outputs
  // Interrupt is a level from registers, no glitch path
  assign regRdata       = rdata_q;
  assign irq            = |(irqStat_q & irqMask_q);
  assign dacCode        = dac_q;
  assign dacCurrentMode = currentMode;

endmodule : analog_board_code_range_logic

// >>> verification/abrd_monitor.sv
// Checker of the code range logic: host register shadows and port relations
// Assumes it is bound into analog_board_code_range_logic and sees its ports only
`timescale 1ns/100ps
`include "abrd_defs.svh"

module abrd_monitor (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdata,
  input wire logic        irq,
  input wire logic [15:0] dacCode
);
  logic        [6:0]  ctrl_q, ctrl_d;
  logic signed [15:0] out_q, out_d;
  logic        [15:0] subst_q, subst_d;
  logic        [4:0]  mask_q, mask_d;
  logic        [2:0]  quiet_q, quiet_d;
  logic               badCode;
  logic               stRead;

  // Next values of the shadowed host registers
  always_comb begin
    ctrl_d  = ctrl_q;
    out_d   = out_q;
    subst_d = subst_q;
    mask_d  = mask_q;
    quiet_d = (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
    if (regWrite) begin
      quiet_d = 3'h0;
      case (regAddr)
        `ABRD_OFF_CTRL:     ctrl_d  = regWdata[6:0];
        `ABRD_OFF_OUT_DATA: out_d   = regWdata[15:0];
        `ABRD_OFF_SUBST:    subst_d = regWdata[15:0];
        `ABRD_OFF_IRQ_MASK: mask_d  = regWdata[4:0];
        default:            ;
      endcase
    end
  end

  // Shadow registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {ctrl_q, out_q, subst_q, mask_q, quiet_q} <= '0;
    end else begin
      {ctrl_q, out_q, subst_q, mask_q, quiet_q} <= {ctrl_d, out_d, subst_d, mask_d, quiet_d};
    end
  end

  // Host code the converter must not follow; status read once settled
  assign badCode = (out_q >= `ABRD_OVF_MIN) || (out_q < `ABRD_UNDER_MIN)
                   || (ctrl_q[1] && out_q < 0);
  assign stRead  = regRead && regAddr == `ABRD_OFF_STATUS && quiet_q >= 3'h4;

  default clocking mon_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  pass_code_a: assert property (ctrl_q[0] && !badCode |=> dacCode == $past(out_q))
    else $error("dac code is not the host code");
  react_a: assert property ((!ctrl_q[0] || badCode)
    |=> dacCode == ($past(ctrl_q[2]) ? $past(subst_q) : $past(dacCode)))
    else $error("dac reaction value wrong");
  rd_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
    else $error("read data outside read slot");
  rd_ctrl_a: assert property (regRead && regAddr == `ABRD_OFF_CTRL
    |=> regRdata == {25'h0, $past(ctrl_q)})
    else $error("control readback wrong");
  rd_unmapped_a: assert property (regRead && regAddr > `ABRD_OFF_IRQ_MASK |=> regRdata == 0)
    else $error("unmapped read not zero");
  range_flag_a: assert property (stRead |=> regRdata[6] == $past(badCode))
    else $error("output range flag wrong");
  short_gate_a: assert property (stRead && ctrl_q[1] |=> !regRdata[8])
    else $error("short flag in current mode");
  wire_gate_a: assert property (stRead && !ctrl_q[1] |=> !regRdata[9])
    else $error("wire break flag in voltage mode");
  irq_mask_a: assert property (mask_q == 5'h00 |-> !irq)
    else $error("interrupt while fully masked");

  cover property (ctrl_q[0] && badCode);
  cover property (!ctrl_q[0] && ctrl_q[2]);
  cover property (irq);
endmodule : abrd_monitor

bind analog_board_code_range_logic abrd_monitor u_monitor (
  .clk_sys, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq, .dacCode
);

// >>> verification/analog_front_model.sv
// Analog front end stand-in: converter word and fault lines toward the board
// Assumes the bench sets the wanted levels; pins follow one edge later
`timescale 1ns/100ps

module analog_front_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] adcSet,
  input  wire logic        shortSet,
  input  wire logic        wireSet,
  output logic      [15:0] adcCode,
  output logic             shortToGndPin,
  output logic             wireBreakPin
);
  // Levels change just after an edge, one edge behind the bench
  always @(posedge clk_sys) begin
    adcCode       <= adcSet;
    shortToGndPin <= shortSet;
    wireBreakPin  <= wireSet;
  end
endmodule : analog_front_model

// >>> verification/analog_board_code_range_logic_tb.sv
// Bench of the code range logic: register tasks and one task per scenario
// Assumes the design, its monitor and analog_front_model are compiled first
`timescale 1ns/100ps
`include "abrd_defs.svh"

module analog_board_code_range_logic_tb;
  import abrd_pkg::*;
  localparam int PER [4] = '{20, 30, 40, 50};
  logic        clk_sys, rstn, regWrite, regRead, irq, shortSet, wireSet;
  logic        shortToGndPin, wireBreakPin, dacCurrentMode;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [15:0] dacCode, adcCode, adcSet;
  int          errTotal = 0;
  int          nChecks = 0;
  int          cyc = 0;
  time         t0, t1;

  analog_board_code_range_logic #(
    .SAMP_CYC_400(PER[0]), .SAMP_CYC_60(PER[1]), .SAMP_CYC_50(PER[2]), .SAMP_CYC_10(PER[3])
  ) u_dut (
    .clk_sys, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .irq, .dacCode,
    .dacCurrentMode, .adcCode, .shortToGndPin, .wireBreakPin
  );
  analog_front_model u_front (
    .clk_sys, .adcSet, .shortSet, .wireSet, .adcCode, .shortToGndPin, .wireBreakPin
  );

  // Clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      errTotal++;
      final_report;
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_dac(input logic [15:0] exp);
    chk_reg({16'h0, dacCode}, {16'h0, exp});
  endtask : chk_dac

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk_reg(v, exp);
  endtask : rdchk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc

  // Waits for the input update interrupt, stamps it and clears it
  task automatic wait_upd(output time t);
    int n;
    n = 0;
    #1;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 200) begin
      errTotal++;
    end
    t = $time;
    wr(`ABRD_OFF_IRQ_STAT, 32'h10);
  endtask : wait_upd

  function automatic codeBand_t band_of(input logic signed [15:0] c, input logic cur);
    if (c >= 16'sh7f00) return BAND_OVERFLOW;
    if (c < 16'sh8100 || (cur && c < 0)) return BAND_UNDERFLOW;
    if (c > 16'sh6c00) return BAND_OVERSHOOT;
    if (c < 16'sh9400) return BAND_UNDERSHOOT;
    return BAND_RATED;
  endfunction : band_of

  task automatic t_reset;
    wr(`ABRD_OFF_STATUS, 32'hffff_ffff);
    wr(`ABRD_OFF_IN_DATA, 32'h0000_1234);
    rdchk(`ABRD_OFF_CTRL, 32'h0);
    rdchk(`ABRD_OFF_SUBST, 32'h0);
    rdchk(`ABRD_OFF_STATUS, 32'h0);
    rdchk(`ABRD_OFF_IN_DATA, 32'h0);
    rdchk(8'h1c, 32'h0);
    chk_dac(16'h0);
  endtask : t_reset

  // Band edges of both modes with substitute or keep-last reaction
  task automatic t_out(input logic [31:0] ctrl);
    logic [15:0] codes [10] = '{16'h6c00, 16'h9400, 16'h7eff, 16'h8100, 16'h7f00,
                                16'h80ff, 16'h7fff, 16'h8000, 16'h6c01, 16'hffff};
    logic [15:0] last;
    codeBand_t   b;
    last = 16'h0;
    wr(`ABRD_OFF_SUBST, 32'h1234);
    wr(`ABRD_OFF_CTRL, ctrl);
    for (int i = 0; i < 10; i++) begin
      b = band_of(codes[i], ctrl[1]);
      wr(`ABRD_OFF_OUT_DATA, {16'h0, codes[i]});
      wait_cyc(4);
      last = (b >= BAND_OVERFLOW) ? (ctrl[2] ? 16'h1234 : last) : codes[i];
      chk_dac(last);
      rd(`ABRD_OFF_STATUS, d);
      chk_reg({24'h0, d[10:6], d[2:0]}, {24'h0, 4'b1000, b >= BAND_OVERFLOW, b});
    end
    chk_reg({31'h0, dacCurrentMode}, {31'h0, ctrl[1]});
  endtask : t_out

  task automatic t_stop;
    wr(`ABRD_OFF_SUBST, 32'hf000);
    wr(`ABRD_OFF_CTRL, 32'h1);
    wr(`ABRD_OFF_OUT_DATA, 32'h64);
    wait_cyc(4);
    chk_dac(16'h64);
    wr(`ABRD_OFF_CTRL, 32'h0);
    wr(`ABRD_OFF_OUT_DATA, 32'hc8);
    wait_cyc(4);
    chk_dac(16'h64);
    wr(`ABRD_OFF_CTRL, 32'h4);
    wait_cyc(4);
    chk_dac(16'hf000);
  endtask : t_stop

  task automatic t_diag;
    wr(`ABRD_OFF_CTRL, 32'h1);
    wr(`ABRD_OFF_IRQ_STAT, 32'h1f);
    wr(`ABRD_OFF_IRQ_MASK, 32'hc);
    shortSet <= 1'b1;
    wireSet  <= 1'b1;
    wait_cyc(8);
    rd(`ABRD_OFF_STATUS, d);
    chk_reg({30'h0, d[9:8]}, 32'h1);
    chk_reg({31'h0, irq}, 32'h1);
    wr(`ABRD_OFF_CTRL, 32'h3);
    wait_cyc(8);
    rd(`ABRD_OFF_STATUS, d);
    chk_reg({30'h0, d[9:8]}, 32'h2);
    @(posedge clk_sys);
    shortSet <= 1'b0;
    wireSet  <= 1'b0;
    wait_cyc(8);
    wr(`ABRD_OFF_IRQ_STAT, 32'hc);
    wait_cyc(2);
    chk_reg({31'h0, irq}, 32'h0);
  endtask : t_diag

  // Weak smoothing ramp, then input bands with no smoothing
  task automatic t_input;
    logic [15:0] codes [3] = '{16'h7f58, 16'h8000, 16'h6c00};
    codeBand_t   bands [3] = '{BAND_OVERFLOW, BAND_UNDERFLOW, BAND_RATED};
    wr(`ABRD_OFF_CTRL, 32'h9);
    wr(`ABRD_OFF_IRQ_MASK, 32'h10);
    wr(`ABRD_OFF_IRQ_STAT, 32'h1f);
    wait_upd(t0);
    adcSet <= 16'd400;
    for (int i = 1; i <= 4; i++) begin
      wait_upd(t0);
      rdchk(`ABRD_OFF_IN_DATA, 32'(100 * i));
    end
    wr(`ABRD_OFF_CTRL, 32'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      adcSet <= codes[i];
      wait_upd(t0);
      wait_upd(t0);
      rdchk(`ABRD_OFF_IN_DATA, {16'h0, codes[i]});
      rd(`ABRD_OFF_STATUS, d);
      chk_reg({28'h0, d[7], d[5:3]}, {28'h0, bands[i] >= BAND_OVERFLOW, bands[i]});
    end
  endtask : t_input

  // Step from zero seen through the 32, then the 16 sample window
  task automatic t_window;
    wr(`ABRD_OFF_CTRL, 32'h19);
    adcSet <= 16'h0;
    repeat (34) wait_upd(t0);
    adcSet <= 16'd3200;
    repeat (4) wait_upd(t0);
    rdchk(`ABRD_OFF_IN_DATA, 32'd400);
    wr(`ABRD_OFF_CTRL, 32'h11);
    wait_upd(t0);
    rdchk(`ABRD_OFF_IN_DATA, 32'd1000);
  endtask : t_window

  task automatic t_period;
    for (int i = 0; i < 4; i++) begin
      wr(`ABRD_OFF_CTRL, 32'(1 + (i << 5)));
      wait_upd(t0);
      wait_upd(t0);
      wait_upd(t1);
      chk_reg(32'((t1 - t0) / 8), 32'(PER[i]));
    end
  endtask : t_period

  // Reset, then the scenarios in turn
  initial begin
    {rstn, regWrite, regRead, shortSet, wireSet} = 5'h0;
    regAddr  = 8'h00;
    regWdata = 32'h0;
    adcSet   = 16'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_out(32'h5);
    t_out(32'h3);
    t_stop;
    t_diag;
    t_input;
    t_window;
    t_period;
    final_report;
  end
endmodule : analog_board_code_range_logic_tb
